/* src/pin_override_pkg.sv */
// Types shared by the pin override block
`default_nettype none
package pin_override_pkg;
  typedef logic [7:0] port_t;
  typedef logic [1:0] axi_resp_t;
endpackage
`default_nettype wire

/* src/pin_override_regs.svh */
// Register offsets, field positions and reset values of the pin override block
`ifndef PIN_OVERRIDE_REGS_SVH
`define PIN_OVERRIDE_REGS_SVH
`define CHIP_CONTROL_OFFSET 8'h00
`define PORT_A_DIR_OFFSET 8'h04
`define PORT_A_OUT_OFFSET 8'h08
`define PORT_B_DIR_OFFSET 8'h0C
`define PORT_B_OUT_OFFSET 8'h10
`define DISPLAY_CTRL_OFFSET 8'h14
`define PORT_A_TOGGLE_OFFSET 8'h18
`define PORT_B_TOGGLE_OFFSET 8'h1C
`define PAD_STATUS_OFFSET 8'h20
`define CHIP_CONTROL_RESET 8'h00
`define CHIP_CONTROL_WMASK 8'h93
`define GLOBAL_PULLUP_OFF_BIT 4
`define DISPLAY_ENABLE_BIT 0
`define DISPLAY_DUTY_LSB 1
`define DISPLAY_CTRL_RESET 8'h00
`define PORT_RESET 8'h00
`endif

/* src/port_pin_override_logic.sv */
// Pin override muxes for ports A and B with AXI4-Lite register access
// Behaviour
// RQ1: Pull-up follows override value, else on when direction,output,global-off equal 010.
// RQ2: Driver enable follows direction override value when enabled, else direction bit.
// RQ3: Driven value is value override when enabled, else output bit.
// RQ4: Toggle override enable inverts the pin output bit.
// RQ5: Input enable follows override value when enabled, else sleep clamping state.
// RQ6: Alternate input taken before synchroniser; receiver synchronises unless used as clock.
// RQ7: Analog link ties directly to the pad, no logic, both directions.
// RQ8: Strobes shared per port; clock, sleep, global pull-up off shared; overrides per pin.
// RQ9: Each peripheral generates its own override enables and values.
// RQ10: Chip control bit 4 disables all pull-ups; register resets to zero; enabled port B pull-up overrides still set the pull-up.
// RQ11: Display enable overrides pull-up, direction, input enable of port A upper pins to 0.
// RQ12: Port A pins 3..1 overridden when duty select exceeds 2,1,0; pin 0 always.
// RQ13: Port A pins 7..4 carry segment lines 3..0, pins 3..0 backplane lines 3..0.
// RQ14: Port B carries timer compares, SPI signals, pin change sources 15..8.
// RQ15: Override selection is combinational per pin with no added latency; the pad outputs are then registered, one cycle later.
`include "pin_override_regs.svh"
`default_nettype none
module port_pin_override_logic (
  input wire logic i_mclk, // I/O clock, shared by all ports
  input wire logic i_nrst, // Async reset, active low
  input wire logic i_sleep, // Sleep clamp request, shared
  // AXI4-Lite slave
  input wire logic [7:0] i_awaddr, // Write address
  input wire logic i_awvalid, // Write address valid
  output logic o_awready, // Write address ready
  input wire logic [31:0] i_wdata, // Write data
  input wire logic [3:0] i_wstrb, // Write strobes
  input wire logic i_wvalid, // Write data valid
  output logic o_wready, // Write data ready
  output logic [1:0] o_bresp, // Write response
  output logic o_bvalid, // Write response valid
  input wire logic i_bready, // Write response ready
  input wire logic [7:0] i_araddr, // Read address
  input wire logic i_arvalid, // Read address valid
  output logic o_arready, // Read address ready
  output logic [31:0] o_rdata, // Read data
  output logic [1:0] o_rresp, // Read response
  output logic o_rvalid, // Read data valid
  input wire logic i_rready, // Read data ready
  // Port B peripheral overrides, one bit per pin
  input wire logic [7:0] i_pb_pullup_override_en, // Pull-up override enable
  input wire logic [7:0] i_pb_pullup_override_val, // Pull-up override value
  input wire logic [7:0] i_pb_direction_override_en, // Direction override enable
  input wire logic [7:0] i_pb_direction_override_val, // Direction override value
  input wire logic [7:0] i_pb_value_override_en, // Value override enable
  input wire logic [7:0] i_pb_value_override_val, // Value override value
  input wire logic [7:0] i_pb_toggle_override_en, // Toggle override enable
  input wire logic [7:0] i_pb_input_enable_override_en, // Input enable override enable
  input wire logic [7:0] i_pb_input_enable_override_val, // Input enable override value
  // Pads
  input wire logic [7:0] i_pa_pad, // Port A pad level (after Schmitt)
  input wire logic [7:0] i_pb_pad, // Port B pad level (after Schmitt)
  output logic [7:0] o_pa_pad, // Port A driven value
  output logic [7:0] o_pa_pad_oe_n, // Port A driver enable, low drives
  output logic [7:0] o_pa_pullup, // Port A pull-up enable
  output logic [7:0] o_pa_input_en, // Port A digital input enable
  output logic [7:0] o_pb_pad, // Port B driven value
  output logic [7:0] o_pb_pad_oe_n, // Port B driver enable, low drives
  output logic [7:0] o_pb_pullup, // Port B pull-up enable
  output logic [7:0] o_pb_input_en, // Port B digital input enable
  output logic [7:0] o_pb_alt_func_input, // Port B alternate inputs to peripherals
  output logic o_display_drive_enable, // Display drive enable
  output logic [1:0] o_display_duty_select // Display duty select
);

  // Pull-up: override, else {dir,out,off}==010
  function automatic logic pullup_sel(input logic oe, input logic ov, input logic dir, input logic out,
                                      input logic off);
    pullup_sel = oe ? ov : (!dir && out && !off);
  endfunction

  // Write a byte from lane 0 if strobed
  function automatic pin_override_pkg::port_t lane0(input pin_override_pkg::port_t old, input logic [31:0] d,
                                                     input logic [3:0] s);
    lane0 = s[0] ? d[7:0] : old;
  endfunction

  pin_override_pkg::port_t chip_control_reg, chip_control_next;
  pin_override_pkg::port_t pa_dir_reg, pa_dir_next;
  pin_override_pkg::port_t pa_out_reg, pa_out_next;
  pin_override_pkg::port_t pb_dir_reg, pb_dir_next;
  pin_override_pkg::port_t pb_out_reg, pb_out_next;
  pin_override_pkg::port_t display_ctrl_reg, display_ctrl_next;
  logic aw_have_reg;
  logic w_have_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] bresp_reg;
  logic [1:0] rresp_reg;

  // Shared controls (RQ8: sleep, pull-up off common to all pins)
  wire logic global_pullup_off = chip_control_reg[`GLOBAL_PULLUP_OFF_BIT];
  wire logic display_drive_enable = display_ctrl_reg[`DISPLAY_ENABLE_BIT];
  wire logic [1:0] display_duty_select = display_ctrl_reg[`DISPLAY_DUTY_LSB +: 2];

  // RQ12: backplane pins by duty select
  wire logic [3:0] pa_low_ovr = {display_drive_enable && (display_duty_select > 2'h2),
                                 display_drive_enable && (display_duty_select > 2'h1),
                                 display_drive_enable && (display_duty_select > 2'h0),
                                 display_drive_enable};
  // RQ11: segment pins all follow display enable
  // RQ13: segments high, backplanes low
  wire pin_override_pkg::port_t pa_ovr_en = {{4{display_drive_enable}}, pa_low_ovr};

  // Write channel handshake; a beat moves only while its ready is high
  wire logic aw_take = i_awvalid && o_awready;
  wire logic w_take = i_wvalid && o_wready;
  wire logic aw_now = aw_have_reg || aw_take;
  wire logic w_now = w_have_reg || w_take;
  wire logic wr_fire = aw_now && w_now && !bvalid_reg;
  // Slot and response state after this edge
  wire logic aw_have_next = aw_now && !wr_fire;
  wire logic w_have_next = w_now && !wr_fire;
  wire logic bvalid_next = wr_fire || (bvalid_reg && !i_bready);
  wire logic [7:0] wr_addr = aw_have_reg ? awaddr_reg : i_awaddr;
  wire logic [31:0] wr_data = w_have_reg ? wdata_reg : i_wdata;
  wire logic [3:0] wr_strb = w_have_reg ? wstrb_reg : i_wstrb;
  wire logic wr_hit = (wr_addr == `CHIP_CONTROL_OFFSET) || (wr_addr == `PORT_A_DIR_OFFSET) ||
                      (wr_addr == `PORT_A_OUT_OFFSET) || (wr_addr == `PORT_B_DIR_OFFSET) ||
                      (wr_addr == `PORT_B_OUT_OFFSET) || (wr_addr == `DISPLAY_CTRL_OFFSET) ||
                      (wr_addr == `PORT_A_TOGGLE_OFFSET) || (wr_addr == `PORT_B_TOGGLE_OFFSET);
  // Toggle writes act for one cycle, nothing is stored
  wire pin_override_pkg::port_t wr_byte = wr_strb[0] ? wr_data[7:0] : 8'h00;
  wire pin_override_pkg::port_t pa_sw_toggle = (wr_fire && wr_addr == `PORT_A_TOGGLE_OFFSET) ? wr_byte : 8'h00;
  wire pin_override_pkg::port_t pb_sw_toggle = (wr_fire && wr_addr == `PORT_B_TOGGLE_OFFSET) ? wr_byte : 8'h00;

  // Register next values
  always_comb begin
    chip_control_next = chip_control_reg;
    pa_dir_next = pa_dir_reg;
    pb_dir_next = pb_dir_reg;
    display_ctrl_next = display_ctrl_reg;
    pa_out_next = pa_out_reg ^ pa_sw_toggle;
    // RQ4: toggle override inverts output bit
    pb_out_next = pb_out_reg ^ pb_sw_toggle ^ i_pb_toggle_override_en;
    // Mapped writes land on the fire edge
    if (wr_fire) begin
      unique case (wr_addr)
        // RQ10: writable bits incl. pull-up off
        `CHIP_CONTROL_OFFSET: chip_control_next = lane0(chip_control_reg, wr_data & {24'h0, `CHIP_CONTROL_WMASK},
                                                        wr_strb);
        `PORT_A_DIR_OFFSET: pa_dir_next = lane0(pa_dir_reg, wr_data, wr_strb);
        `PORT_A_OUT_OFFSET: pa_out_next = lane0(pa_out_reg, wr_data, wr_strb);
        `PORT_B_DIR_OFFSET: pb_dir_next = lane0(pb_dir_reg, wr_data, wr_strb);
        `PORT_B_OUT_OFFSET: pb_out_next = lane0(pb_out_reg, wr_data, wr_strb) ^ i_pb_toggle_override_en;
        `DISPLAY_CTRL_OFFSET: display_ctrl_next = lane0(display_ctrl_reg, wr_data & 32'h0000_0007, wr_strb);
        default: ;
      endcase
    end
  end

  // Read decode
  wire logic rd_take = i_arvalid && o_arready;
  wire logic rvalid_next = rd_take || (rvalid_reg && !i_rready);
  wire logic [31:0] rd_word = (i_araddr == `CHIP_CONTROL_OFFSET) ? {24'h0, chip_control_reg} :
                              (i_araddr == `PORT_A_DIR_OFFSET) ? {24'h0, pa_dir_reg} :
                              (i_araddr == `PORT_A_OUT_OFFSET) ? {24'h0, pa_out_reg} :
                              (i_araddr == `PORT_B_DIR_OFFSET) ? {24'h0, pb_dir_reg} :
                              (i_araddr == `PORT_B_OUT_OFFSET) ? {24'h0, pb_out_reg} :
                              (i_araddr == `DISPLAY_CTRL_OFFSET) ? {24'h0, display_ctrl_reg} :
                              (i_araddr == `PAD_STATUS_OFFSET) ? {16'h0, i_pb_pad, i_pa_pad} : 32'h0000_0000;
  // Unmapped reads answer with a slave error
  wire logic rd_hit = (i_araddr == `CHIP_CONTROL_OFFSET) || (i_araddr == `PORT_A_DIR_OFFSET) ||
                      (i_araddr == `PORT_A_OUT_OFFSET) || (i_araddr == `PORT_B_DIR_OFFSET) ||
                      (i_araddr == `PORT_B_OUT_OFFSET) || (i_araddr == `DISPLAY_CTRL_OFFSET) ||
                      (i_araddr == `PORT_A_TOGGLE_OFFSET) || (i_araddr == `PORT_B_TOGGLE_OFFSET) ||
                      (i_araddr == `PAD_STATUS_OFFSET);

  // RQ7: analog link bypasses logic
  // Port A pad controls (RQ15 combinational muxes)
  // RQ11: overrides force pull-up, direction, input enable to 0
  wire pin_override_pkg::port_t pa_pullup_c, pa_drive_c, pa_value_c, pa_input_c;
  // RQ2: driver enable mux
  assign pa_drive_c = ~pa_ovr_en & pa_dir_reg;
  // RQ3: port A has no value override
  assign pa_value_c = pa_out_reg;
  // RQ5: input enable override, else sleep clamp
  assign pa_input_c = ~pa_ovr_en & {8{!i_sleep}};

  // Port B pad controls
  // RQ14: port B alternate pins
  wire pin_override_pkg::port_t pb_pullup_c, pb_drive_c, pb_value_c, pb_input_c;
  // RQ2: direction override mux
  assign pb_drive_c = (i_pb_direction_override_en & i_pb_direction_override_val) |
                      (~i_pb_direction_override_en & pb_dir_reg);
  // RQ3: value override mux
  assign pb_value_c = (i_pb_value_override_en & i_pb_value_override_val) | (~i_pb_value_override_en & pb_out_reg);
  // RQ5: input enable override mux
  assign pb_input_c = (i_pb_input_enable_override_en & i_pb_input_enable_override_val) |
                      (~i_pb_input_enable_override_en & {8{!i_sleep}});

  // RQ1: pull-up per pin
  generate
    for (genvar n = 0; n < 8; n++) begin : g_pull
      assign pa_pullup_c[n] = pullup_sel(pa_ovr_en[n], 1'b0, pa_dir_reg[n], pa_out_reg[n], global_pullup_off);
      assign pb_pullup_c[n] = pullup_sel(i_pb_pullup_override_en[n], i_pb_pullup_override_val[n], pb_dir_reg[n],
                                         pb_out_reg[n], global_pullup_off);
    end
  endgenerate

  // Software-visible registers
  // Toggle override acts through pb_out_next
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      chip_control_reg <= `CHIP_CONTROL_RESET;
      pa_dir_reg <= `PORT_RESET;
      pa_out_reg <= `PORT_RESET;
      pb_dir_reg <= `PORT_RESET;
      pb_out_reg <= `PORT_RESET;
      display_ctrl_reg <= `DISPLAY_CTRL_RESET;
    end else begin
      chip_control_reg <= chip_control_next;
      pa_dir_reg <= pa_dir_next;
      pa_out_reg <= pa_out_next;
      pb_dir_reg <= pb_dir_next;
      pb_out_reg <= pb_out_next;
      display_ctrl_reg <= display_ctrl_next;
    end
  end

  // Write address and data slots
  // Each slot holds one beat until its partner arrives
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      if (aw_take) begin
        awaddr_reg <= i_awaddr;
      end
      if (w_take) begin
        wdata_reg <= i_wdata;
        wstrb_reg <= i_wstrb;
      end
    end
  end

  // Write response, held until taken
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
    end else begin
      bvalid_reg <= bvalid_next;
      // Unmapped offsets answer with a slave error
      if (wr_fire) begin
        bresp_reg <= wr_hit ? 2'h0 : 2'h2;
      end
    end
  end

  // Read response, held until taken
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'h0;
    end else begin
      rvalid_reg <= rvalid_next;
      if (rd_take) begin
        rdata_reg <= rd_word;
        rresp_reg <= rd_hit ? 2'h0 : 2'h2;
      end
    end
  end

  // Ready flops look one edge ahead
  // A beat seen with ready high is always taken
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_arready <= 1'b0;
    end else begin
      o_awready <= !aw_have_next && !bvalid_next;
      o_wready <= !w_have_next && !bvalid_next;
      o_arready <= !rvalid_next;
    end
  end

  // Port A pad control flops
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pa_pad <= 8'h00;
      o_pa_pad_oe_n <= 8'hFF;
      o_pa_pullup <= 8'h00;
      o_pa_input_en <= 8'h00;
    end else begin
      o_pa_pad <= pa_value_c;
      o_pa_pad_oe_n <= ~pa_drive_c;
      o_pa_pullup <= pa_pullup_c;
      o_pa_input_en <= pa_input_c;
    end
  end

  // Port B pad control flops and alternate inputs
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pb_pad <= 8'h00;
      o_pb_pad_oe_n <= 8'hFF;
      o_pb_pullup <= 8'h00;
      o_pb_input_en <= 8'h00;
      o_pb_alt_func_input <= 8'h00;
    end else begin
      o_pb_pad <= pb_value_c;
      o_pb_pad_oe_n <= ~pb_drive_c;
      o_pb_pullup <= pb_pullup_c;
      o_pb_input_en <= pb_input_c;
      // RQ6: alternate input without pin synchroniser
      o_pb_alt_func_input <= i_pb_pad & pb_input_c;
    end
  end

  // Display control copies
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_display_drive_enable <= 1'b0;
      o_display_duty_select <= 2'h0;
    end else begin
      o_display_drive_enable <= display_drive_enable;
      o_display_duty_select <= display_duty_select;
    end
  end

  // AXI outputs
  assign o_bvalid = bvalid_reg;
  assign o_bresp = bresp_reg;
  assign o_rvalid = rvalid_reg;
  assign o_rdata = rdata_reg;
  assign o_rresp = rresp_reg;

endmodule // port_pin_override_logic
`default_nettype wire

/* testbench/pad_peripheral_model.sv */
// Pad level model for one port
`default_nettype none
module pad_peripheral_model (
  input wire logic i_mclk, // Clock
  input wire logic [7:0] i_out, // Driven value
  input wire logic [7:0] i_oe_n, // Low drives
  input wire logic [7:0] i_pullup, // Pull-up on
  input wire logic [7:0] i_ext_en, // Outside drives
  input wire logic [7:0] i_ext_val, // Outside value
  output logic [7:0] o_level // Pad level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] float_reg = 8'h55;
  // Undriven pins without pull-up wander
  always @(posedge i_mclk) float_reg <= ~float_reg;
  assign o_level = (~i_oe_n & i_out) | (i_oe_n & ((i_ext_en & i_ext_val) | (~i_ext_en & (i_pullup | float_reg))));
endmodule // pad_peripheral_model
`default_nettype wire

/* testbench/port_pin_override_checker.sv */
// Port assertions for the pin override block
`default_nettype none
module port_pin_override_checker (
  input wire logic i_mclk, // Clock
  input wire logic i_nrst, // Reset
  input wire logic i_sleep, // Sleep
  input wire logic i_bready, // B ready
  input wire logic o_bvalid, // B valid
  input wire logic [7:0] i_pb_pullup_override_en, // PU en
  input wire logic [7:0] i_pb_pullup_override_val, // PU val
  input wire logic [7:0] i_pb_direction_override_en, // Dir en
  input wire logic [7:0] i_pb_direction_override_val, // Dir val
  input wire logic [7:0] i_pb_value_override_en, // Value en
  input wire logic [7:0] i_pb_toggle_override_en, // Toggle en
  input wire logic [7:0] i_pb_input_enable_override_en, // IE en
  input wire logic [7:0] i_pb_input_enable_override_val, // IE val
  input wire logic [7:0] o_pa_pad_oe_n, // PA oe
  input wire logic [7:0] o_pa_pullup, // PA pull-up
  input wire logic [7:0] o_pa_input_en, // PA input
  input wire logic [7:0] o_pb_pad, // PB value
  input wire logic [7:0] o_pb_pad_oe_n, // PB oe
  input wire logic [7:0] o_pb_pullup, // PB pull-up
  input wire logic [7:0] o_pb_input_en, // PB input
  input wire logic o_display_drive_enable, // Display on
  input wire logic [1:0] o_display_duty_select // Duty
);
  timeunit 1ns;
  timeprecision 1ps;
  logic up_reg;
  logic [3:0] back_mask;
  logic tog7;
  // Armed once the first edge after reset has passed
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) up_reg <= 1'b0;
    else up_reg <= 1'b1;
  end
  // Backplane pins taken over, toggle on pin 7
  assign back_mask = {&o_display_duty_select, o_display_duty_select[1], |o_display_duty_select, 1'b1}
    & {4{o_display_drive_enable}};
  assign tog7 = i_pb_toggle_override_en[7] & ~i_pb_value_override_en[7];
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  sequence s_tog_held;
    (tog7 && up_reg) [*2];
  endsequence
  chk_pullup_override: assert property (up_reg |-> ((o_pb_pullup ^ $past(i_pb_pullup_override_val))
    & $past(i_pb_pullup_override_en)) == 8'h00) else $error("pull-up override wrong");
  chk_driver_override: assert property (up_reg |-> ((o_pb_pad_oe_n ^ ~$past(i_pb_direction_override_val))
    & $past(i_pb_direction_override_en)) == 8'h00) else $error("driver override wrong");
  chk_input_override: assert property (up_reg |-> ((o_pb_input_en ^ $past(i_pb_input_enable_override_val))
    & $past(i_pb_input_enable_override_en)) == 8'h00) else $error("input override wrong");
  chk_sleep_clamp: assert property (up_reg |-> ((o_pb_input_en ^ {8{!$past(i_sleep)}})
    & ~$past(i_pb_input_enable_override_en)) == 8'h00) else $error("sleep clamp wrong");
  chk_segment_pins: assert property (up_reg && $past(o_display_drive_enable) && o_display_drive_enable
    |-> o_pa_pad_oe_n[7:4] == 4'hF && (o_pa_pullup[7:4] | o_pa_input_en[7:4]) == 4'h0)
    else $error("segment pins not released");
  chk_backplane_pins: assert property (up_reg && $stable(back_mask) |-> (o_pa_pad_oe_n[3:0] & back_mask)
    == back_mask && ((o_pa_pullup[3:0] | o_pa_input_en[3:0]) & back_mask) == 4'h0)
    else $error("backplane pins not released");
  chk_toggle_flip: assert property (s_tog_held |=> o_pb_pad[7] != $past(o_pb_pad[7]))
    else $error("toggle did not invert");
  chk_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid)
    else $error("write response dropped");
endmodule // port_pin_override_checker
bind port_pin_override_logic port_pin_override_checker u_port_pin_override_checker (
  .i_mclk, .i_nrst, .i_sleep, .i_bready, .o_bvalid, .i_pb_pullup_override_en,
  .i_pb_pullup_override_val, .i_pb_direction_override_en, .i_pb_direction_override_val,
  .i_pb_value_override_en, .i_pb_toggle_override_en, .i_pb_input_enable_override_en,
  .i_pb_input_enable_override_val, .o_pa_pad_oe_n, .o_pa_pullup, .o_pa_input_en, .o_pb_pad,
  .o_pb_pad_oe_n, .o_pb_pullup, .o_pb_input_en, .o_display_drive_enable, .o_display_duty_select);
`default_nettype wire

/* testbench/tb_port_pin_override_logic.sv */
// Self-checking bench for the pin override block
`include "pin_override_regs.svh"
`default_nettype none
module tb_port_pin_override_logic;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk = 1'b0, i_nrst, i_sleep, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_display_drive_enable;
  logic [1:0] o_bresp, o_rresp, o_display_duty_select;
  logic [3:0] i_wstrb;
  logic [7:0] i_awaddr, i_araddr, i_pa_pad, i_pb_pad, ext_en, ext_val, m;
  logic [7:0] i_pb_pullup_override_en, i_pb_pullup_override_val, i_pb_direction_override_en;
  logic [7:0] i_pb_direction_override_val, i_pb_value_override_en, i_pb_value_override_val;
  logic [7:0] i_pb_toggle_override_en, i_pb_input_enable_override_en, i_pb_input_enable_override_val;
  logic [7:0] o_pa_pad, o_pa_pad_oe_n, o_pa_pullup, o_pa_input_en, o_pb_pad, o_pb_pad_oe_n;
  logic [7:0] o_pb_pullup, o_pb_input_en, o_pb_alt_func_input;
  logic [31:0] i_wdata, o_rdata;
  int errors = 0;
  int checks_done = 0;
  always #20 i_mclk = ~i_mclk;
  port_pin_override_logic u_port_pin_override_logic (.i_mclk, .i_nrst, .i_sleep, .i_awaddr, .i_awvalid,
    .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
    .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_pb_pullup_override_en,
    .i_pb_pullup_override_val, .i_pb_direction_override_en, .i_pb_direction_override_val,
    .i_pb_value_override_en, .i_pb_value_override_val, .i_pb_toggle_override_en,
    .i_pb_input_enable_override_en, .i_pb_input_enable_override_val, .i_pa_pad, .i_pb_pad, .o_pa_pad,
    .o_pa_pad_oe_n, .o_pa_pullup, .o_pa_input_en, .o_pb_pad, .o_pb_pad_oe_n, .o_pb_pullup,
    .o_pb_input_en, .o_pb_alt_func_input, .o_display_drive_enable, .o_display_duty_select);
  pad_peripheral_model u_pad_peripheral_model (.i_mclk, .i_out(o_pa_pad), .i_oe_n(o_pa_pad_oe_n),
    .i_pullup(o_pa_pullup), .i_ext_en(8'h00), .i_ext_val(8'h00), .o_level(i_pa_pad));
  pad_peripheral_model u_pad_peripheral_model_b (.i_mclk, .i_out(o_pb_pad), .i_oe_n(o_pb_pad_oe_n),
    .i_pullup(o_pb_pullup), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(i_pb_pad));
  // Compare and verdict
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tick(inout int n);
    @(posedge i_mclk);
    n++;
    if (n > 40) begin
      errors++;
      final_report();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  // Register bus write and read
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    i_awaddr <= a;
    i_wdata <= {24'h0, d};
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    do begin
      tick(n);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
    end while (i_awvalid || i_wvalid);
    i_bready <= 1'b1;
    do tick(n); while (!o_bvalid);
    check({6'h0, o_bresp}, {6'h0, er});
    i_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      tick(n);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
    end while (!o_rvalid);
    check({6'h0, o_rresp}, {6'h0, er});
    if (er === 2'h0) check(o_rdata[7:0], exp);
    check({7'h0, |o_rdata[31:8]}, 8'h00);
    i_rready <= 1'b0;
  endtask
  // Main sequence
  initial begin
    {i_nrst, i_sleep, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 7'h00;
    {i_awaddr, i_araddr, i_wdata, ext_en, ext_val} = '0;
    i_wstrb = 4'h1;
    {i_pb_pullup_override_en, i_pb_pullup_override_val, i_pb_direction_override_en, i_pb_direction_override_val,
      i_pb_value_override_en, i_pb_value_override_val, i_pb_toggle_override_en, i_pb_input_enable_override_en,
      i_pb_input_enable_override_val} = '0;
    cyc(10);
    i_nrst <= 1'b1;
    cyc(2);
    rd(`CHIP_CONTROL_OFFSET, `CHIP_CONTROL_RESET, 2'h0);
    rd(`PORT_A_TOGGLE_OFFSET, 8'h00, 2'h0);
    rd(8'h24, 8'h00, 2'h2);
    wr(8'h24, 8'h01, 2'h2);
    for (int p = 0; p < 2; p++) begin
      wr(`CHIP_CONTROL_OFFSET, p ? 8'h10 : 8'h00, 2'h0);
      wr(`PORT_A_DIR_OFFSET, 8'h33, 2'h0);
      wr(`PORT_A_OUT_OFFSET, 8'h55, 2'h0);
      wr(`PORT_B_DIR_OFFSET, 8'h33, 2'h0);
      wr(`PORT_B_OUT_OFFSET, 8'h55, 2'h0);
      cyc(2);
      check(o_pa_pullup, p ? 8'h00 : 8'h44);
      check(o_pb_pullup, p ? 8'h00 : 8'h44);
      check(o_pa_pad_oe_n, 8'hCC);
      check(o_pa_pad, 8'h55);
      check(o_pb_pad & 8'h33, 8'h11);
    end
    rd(`CHIP_CONTROL_OFFSET, 8'h10, 2'h0);
    wr(`CHIP_CONTROL_OFFSET, 8'h00, 2'h0);
    wr(`PORT_B_DIR_OFFSET, 8'h00, 2'h0);
    wr(`PORT_B_OUT_OFFSET, 8'hFF, 2'h0);
    i_pb_pullup_override_en <= 8'hF0;
    i_pb_pullup_override_val <= 8'hA0;
    i_pb_direction_override_en <= 8'hF0;
    i_pb_direction_override_val <= 8'hA0;
    i_pb_value_override_en <= 8'hF0;
    i_pb_value_override_val <= 8'h80;
    i_pb_input_enable_override_en <= 8'h0F;
    i_pb_input_enable_override_val <= 8'h05;
    ext_en <= 8'h5F;
    ext_val <= 8'h5F;
    for (int s = 0; s < 2; s++) begin
      i_sleep <= s[0];
      cyc(3);
      check(o_pb_pullup, 8'hAF);
      check(o_pb_pad_oe_n, 8'h5F);
      check(o_pb_pad & 8'hA0, 8'h80);
      check(o_pb_input_en, s ? 8'h05 : 8'hF5);
      check(o_pb_alt_func_input, s ? 8'h05 : 8'hD5);
    end
    {i_pb_pullup_override_en, i_pb_direction_override_en, i_pb_value_override_en,
      i_pb_input_enable_override_en, i_sleep} <= '0;
    wr(`PORT_B_DIR_OFFSET, 8'hFF, 2'h0);
    wr(`PORT_B_OUT_OFFSET, 8'h00, 2'h0);
    i_pb_toggle_override_en <= 8'h80;
    cyc(3);
    i_pb_toggle_override_en <= 8'h00;
    rd(`PORT_B_OUT_OFFSET, 8'h80, 2'h0);
    wr(`PORT_A_OUT_OFFSET, 8'h0F, 2'h0);
    wr(`PORT_A_TOGGLE_OFFSET, 8'h3C, 2'h0);
    rd(`PORT_A_OUT_OFFSET, 8'h33, 2'h0);
    wr(`PORT_A_DIR_OFFSET, 8'hFF, 2'h0);
    for (int d = 0; d < 4; d++) begin
      m = {4'hF, d > 2, d > 1, d > 0, 1'b1};
      wr(`DISPLAY_CTRL_OFFSET, {5'h0, d[1:0], 1'b1}, 2'h0);
      cyc(2);
      check(o_pa_pad_oe_n, m);
      check(o_pa_input_en, ~m);
      check(o_pa_pullup, 8'h00);
      check({5'h0, o_display_duty_select, o_display_drive_enable}, {5'h0, d[1:0], 1'b1});
    end
    wr(`DISPLAY_CTRL_OFFSET, 8'h00, 2'h0);
    cyc(2);
    check(o_pa_pad_oe_n, 8'h00);
    i_nrst <= 1'b0;
    cyc(2);
    check(o_pa_pad_oe_n, 8'hFF);
    i_nrst <= 1'b1;
    cyc(2);
    rd(`PORT_A_DIR_OFFSET, `PORT_RESET, 2'h0);
    final_report();
  end
endmodule // tb_port_pin_override_logic
`default_nettype wire
